// ===== ssp_pkg.sv
// Purpose: shared constants and carriers for the simple serial port
// Assumes: 8-bit registers on a plain strobe bus, one clock (mclk)
// Notes: offsets are byte addresses in the processor map
package ssp_pkg;

  localparam int SSP_ADDR_W = 16;
  localparam int SSP_DATA_W = 8;
  localparam int SSP_BITS = 8;
  localparam int SSP_CNT_W = 3;

  // register offsets
  localparam logic [SSP_ADDR_W-1:0] SSP_OFS_CONTROL = 16'h000a;
  localparam logic [SSP_ADDR_W-1:0] SSP_OFS_STATUS = 16'h000b;
  localparam logic [SSP_ADDR_W-1:0] SSP_OFS_DATA = 16'h000c;

  // control field positions
  localparam int SSP_CTL_IRQ_EN = 7;
  localparam int SSP_CTL_PORT_EN = 6;
  localparam int SSP_CTL_ORDER = 5;
  localparam int SSP_CTL_MASTER = 4;
  localparam int SSP_CTL_RATE = 0;

  // status field positions
  localparam int SSP_STS_DONE = 7;
  localparam int SSP_STS_COL = 6;

  // reset values
  localparam logic [SSP_DATA_W-1:0] SSP_CONTROL_RST = 8'h00;
  localparam logic [SSP_DATA_W-1:0] SSP_ZERO_BYTE = 8'h00;

  // port c pin positions
  localparam int SSP_PIN_IN = 0;
  localparam int SSP_PIN_OUT = 1;
  localparam int SSP_PIN_CLK = 2;

  // master bit-rate dividers of mclk
  localparam int SSP_DIV_FAST = 2;
  localparam int SSP_DIV_SLOW = 16;

  // register bus request
  typedef struct packed {
    logic [SSP_ADDR_W-1:0] addr;
    logic [SSP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ssp_bus_req_t;

  // drive for the three port c pins; the block enables only out and clk
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } ssp_pin_drv_t;

endpackage

// ===== ssp_top.sv
// Purpose: three-wire synchronous serial port, master or slave, one byte
// Assumes: mclk is the processor clock; port c glue outside honours pin_owned
// Notes: shift data register has no reset and holds the received byte
`timescale 1ns/100ps
`default_nettype none

module ssp_top
  import ssp_pkg::*;
#(
  parameter int FAST_DIV = SSP_DIV_FAST,
  parameter int SLOW_DIV = SSP_DIV_SLOW
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire ssp_bus_req_t bus_req,
  output logic [SSP_DATA_W-1:0] bus_rdata,
  // processor status
  input wire logic cpu_irq_mask,
  input wire logic stop_mode,
  output logic irq_req,
  // port c glue
  input wire logic [2:0] port_c_direction,
  input wire logic [2:0] port_c_latch,
  output logic [2:0] pin_owned,
  output logic [2:0] port_c_rdata,
  // port c pins
  input wire logic [2:0] pin_in,
  output ssp_pin_drv_t pin_drv
);

  // elaboration checks
  initial
  begin
    if (FAST_DIV < 2 || FAST_DIV % 2 != 0 || FAST_DIV > 2 * (1 << SSP_CNT_W))
      $error("FAST_DIV must be even and 2..16");
    if (SLOW_DIV < 2 || SLOW_DIV % 2 != 0 || SLOW_DIV > 2 * (1 << SSP_CNT_W))
      $error("SLOW_DIV must be even and 2..16");
  end

  localparam logic [SSP_CNT_W-1:0] HALF_FAST = SSP_CNT_W'(FAST_DIV / 2 - 1);
  localparam logic [SSP_CNT_W-1:0] HALF_SLOW = SSP_CNT_W'(SLOW_DIV / 2 - 1);
  localparam logic [SSP_CNT_W-1:0] CNT_LAST = {SSP_CNT_W{1'b1}};

  // bit leaving the register, chosen by order
  function automatic logic out_bit(input logic [SSP_BITS-1:0] v, input logic lsb_first);
    out_bit = lsb_first ? v[0] : v[SSP_BITS-1];
  endfunction

  // shift one step and insert the received bit at the far end
  function automatic logic [SSP_BITS-1:0] shift_in(input logic [SSP_BITS-1:0] v,
                                                   input logic lsb_first, input logic b);
    shift_in = lsb_first ? {b, v[SSP_BITS-1:1]} : {v[SSP_BITS-2:0], b};
  endfunction

  // register state
  logic [SSP_DATA_W-1:0] control_ff;
  logic done_ff;
  logic col_ff;
  logic armed_ff;
  logic busy_ff;
  logic [SSP_CNT_W-1:0] bit_cnt_ff;
  logic [SSP_CNT_W-1:0] div_cnt_ff;
  logic sck_ff;
  logic sdo_ff;
  logic [SSP_BITS-1:0] shreg_ff;
  logic [SSP_DATA_W-1:0] rdata_ff;
  logic [2:0] port_rd_ff;

  // pin synchronisers and filtered levels
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] pin_lvl_ff;
  logic sck_prev_ff;

  // control fields
  logic irq_en;
  logic port_en;
  logic lsb_first;
  logic master;
  logic rate_slow;
  assign irq_en = control_ff[SSP_CTL_IRQ_EN];
  assign port_en = control_ff[SSP_CTL_PORT_EN];
  assign lsb_first = control_ff[SSP_CTL_ORDER];
  assign master = control_ff[SSP_CTL_MASTER];
  assign rate_slow = control_ff[SSP_CTL_RATE];

  // address decode
  logic hit_ctl;
  logic hit_sts;
  logic hit_dat;
  assign hit_ctl = bus_req.addr == SSP_OFS_CONTROL;
  assign hit_sts = bus_req.addr == SSP_OFS_STATUS;
  assign hit_dat = bus_req.addr == SSP_OFS_DATA;

  logic dat_access;
  logic dat_wr_ok;
  logic clear_flags;
  logic collide;
  assign dat_access = hit_dat && (bus_req.wr || bus_req.rd);
  assign collide = port_en && busy_ff && dat_access;
  assign clear_flags = port_en && armed_ff && done_ff && dat_access;
  // writes held off while done unarmed
  assign dat_wr_ok = hit_dat && bus_req.wr && !(port_en && (busy_ff || (done_ff && !armed_ff)));

  logic start;
  assign start = dat_wr_ok && port_en && master;

  // master clock generator events
  logic [SSP_CNT_W-1:0] half_lim;
  logic m_tick;
  assign half_lim = rate_slow ? HALF_SLOW : HALF_FAST;
  assign m_tick = port_en && master && busy_ff && (div_cnt_ff == half_lim);

  // slave edges from the filtered clock pin
  logic s_fall;
  logic s_rise;
  assign s_fall = sck_prev_ff && !pin_lvl_ff[SSP_PIN_CLK];
  assign s_rise = !sck_prev_ff && pin_lvl_ff[SSP_PIN_CLK];

  logic fall_ev;
  logic rise_ev;
  assign fall_ev = port_en && !done_ff && (master ? (m_tick && sck_ff) : s_fall);
  assign rise_ev = port_en && !done_ff && (master ? (m_tick && !sck_ff) : (s_rise && busy_ff));

  logic last_rise;
  assign last_rise = rise_ev && (bit_cnt_ff == CNT_LAST);

  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sync3_ff <= 3'h7;
      pin_lvl_ff <= 3'h7;
      sck_prev_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < 3; i++)
      begin
        if (sync2_ff[i] == sync3_ff[i])
          pin_lvl_ff[i] <= sync3_ff[i];
      end
      sck_prev_ff <= pin_lvl_ff[SSP_PIN_CLK];
    end
  end

  // control register; disabling the port is a write here
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      control_ff <= SSP_CONTROL_RST;
    else if (hit_ctl && bus_req.wr)
      control_ff <= bus_req.wdata;
  end

  // transfer busy, bit counter and clock divider
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !port_en)
    begin
      busy_ff <= 1'b0;
      bit_cnt_ff <= SSP_CNT_W'(0);
      div_cnt_ff <= SSP_CNT_W'(0);
      sck_ff <= 1'b1;
    end
    else
    begin
      if (start)
      begin
        busy_ff <= 1'b1;
        div_cnt_ff <= SSP_CNT_W'(0);
      end
      else if (m_tick)
        div_cnt_ff <= SSP_CNT_W'(0);
      else if (master && busy_ff)
        div_cnt_ff <= div_cnt_ff + SSP_CNT_W'(1);
      // slave transfer begins on the first falling pulse
      if (!master && fall_ev)
        busy_ff <= 1'b1;
      if (last_rise)
        busy_ff <= 1'b0;
      if (m_tick && !last_rise)
        sck_ff <= !sck_ff;
      else if (last_rise)
        sck_ff <= 1'b1;
      if (rise_ev)
        bit_cnt_ff <= bit_cnt_ff + SSP_CNT_W'(1);
    end
  end

  // shift register; no reset, contents start undefined
  always_ff @(posedge mclk)
  begin
    if (dat_wr_ok)
      shreg_ff <= bus_req.wdata;
    else if (rise_ev)
      shreg_ff <= shift_in(shreg_ff, lsb_first, pin_lvl_ff[SSP_PIN_IN]);
  end

  // serial data out changes only on a falling clock
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !port_en)
      sdo_ff <= 1'b1;
    else if (fall_ev)
      sdo_ff <= out_bit(shreg_ff, lsb_first);
  end

  // done and collision flags; a set beats a same-cycle clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !port_en)
    begin
      done_ff <= 1'b0;
      col_ff <= 1'b0;
    end
    else
    begin
      if (last_rise)
        done_ff <= 1'b1;
      else if (clear_flags)
        done_ff <= 1'b0;
      if (collide)
        col_ff <= 1'b1;
      else if (clear_flags)
        col_ff <= 1'b0;
    end
  end

  // status-read arming for the clear sequence
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !port_en)
      armed_ff <= 1'b0;
    else if (hit_sts && bus_req.rd && done_ff)
      armed_ff <= 1'b1;
    else if (dat_access || !done_ff)
      armed_ff <= 1'b0;
  end

  // register read data, valid the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_ff <= SSP_ZERO_BYTE;
    else if (bus_req.rd)
    begin
      rdata_ff <= SSP_ZERO_BYTE;
      if (hit_ctl)
        rdata_ff <= control_ff & 8'hf1;
      else if (hit_sts)
      begin
        rdata_ff[SSP_STS_DONE] <= done_ff;
        rdata_ff[SSP_STS_COL] <= col_ff;
      end
      // busy reads return the moving register, which is unreliable
      else if (hit_dat)
        rdata_ff <= shreg_ff;
    end
  end

  // port c readback while the port owns the pins
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      port_rd_ff <= 3'h0;
    else
      for (int i = 0; i < 3; i++)
        port_rd_ff[i] <= port_c_direction[i] ? port_c_latch[i] : pin_lvl_ff[i];
  end

  // pin ownership and drive; direction bits ignored while enabled
  always_comb
  begin
    pin_owned = {3{port_en}};
    pin_drv.out = 3'h0;
    pin_drv.oe = 3'h0;
    pin_drv.out[SSP_PIN_OUT] = sdo_ff;
    pin_drv.oe[SSP_PIN_OUT] = port_en;
    pin_drv.out[SSP_PIN_CLK] = sck_ff;
    pin_drv.oe[SSP_PIN_CLK] = port_en && master;
  end

  assign irq_req = done_ff && irq_en && !cpu_irq_mask && (!stop_mode || !master);

  assign bus_rdata = rdata_ff;
  assign port_c_rdata = port_rd_ff;

endmodule

`default_nettype wire

// ===== ssp_sva.sv
// Purpose: port-level checks of the serial port
// Assumes: one clock, sync active-low reset
// Notes: control byte mirrored from bus writes
`timescale 1ns/100ps
`default_nettype none
module ssp_sva
  import ssp_pkg::*;
#(
  parameter int FAST_DIV = SSP_DIV_FAST,
  parameter int SLOW_DIV = SSP_DIV_SLOW
)
(
  // clock, reset and bus
  input wire logic mclk,
  input wire logic rst_n,
  input wire ssp_bus_req_t bus_req,
  input wire logic [SSP_DATA_W-1:0] bus_rdata,
  // processor and pins
  input wire logic cpu_irq_mask,
  input wire logic stop_mode,
  input wire logic irq_req,
  input wire logic [2:0] pin_owned,
  input wire ssp_pin_drv_t pin_drv
);
  localparam int HALF_F = FAST_DIV / 2;
  localparam int HALF_S = SLOW_DIV / 2;
  logic [7:0] ctl_ff;
  logic [4:0] low_ff;
  logic [3:0] falls_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // control mirror, taken on the same edge as the port
  always_ff @(posedge mclk)
    if (!rst_n)
      ctl_ff <= 8'h00;
    else if (bus_req.wr && bus_req.addr == SSP_OFS_CONTROL)
      ctl_ff <= bus_req.wdata;
  // cycles the clock pin has been low
  always_ff @(posedge mclk)
    low_ff <= pin_drv.out[2] ? 5'h00 : low_ff + 5'h01;
  // falls since the last data write; a new write restarts the count
  always_ff @(posedge mclk)
    if (!rst_n || !ctl_ff[6] || (bus_req.wr && bus_req.addr == SSP_OFS_DATA))
      falls_ff <= 4'h0;
    else if ($fell(pin_drv.out[2]) && pin_drv.oe[2])
      falls_ff <= falls_ff + 4'h1;
  sequence s_ctl_rd;
    bus_req.rd && bus_req.addr == SSP_OFS_CONTROL;
  endsequence
  sequence s_clk_up;
    $rose(pin_drv.out[2]) && pin_drv.oe[2];
  endsequence
  a_pins_owned: assert property (pin_owned == {3{ctl_ff[6]}})
    else $error("pin ownership differs from enable");
  a_clk_dir: assert property (pin_drv.oe[2] == (ctl_ff[6] && ctl_ff[4]))
    else $error("clock pin direction wrong");
  a_out_enable: assert property (pin_drv.oe[1] == ctl_ff[6] && !pin_drv.oe[0])
    else $error("data pin enables wrong");
  a_phase_len: assert property (s_clk_up |-> low_ff == (ctl_ff[0] ? HALF_S : HALF_F))
    else $error("clock low phase length wrong");
  a_pulse_count: assert property (falls_ff <= 4'h8)
    else $error("more than eight clock pulses");
  a_irq_cause: assert property (irq_req |-> ctl_ff[7] && !cpu_irq_mask && !(stop_mode && ctl_ff[4]))
    else $error("interrupt without its cause");
  a_ctl_read: assert property (s_ctl_rd |=> bus_rdata == (ctl_ff & 8'hf1))
    else $error("control readback wrong");
  a_sts_zero: assert property (bus_req.rd && bus_req.addr == SSP_OFS_STATUS |=> bus_rdata[5:0] == 6'h00)
    else $error("status spare bits not zero");
endmodule
bind ssp_top ssp_sva #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) u_sva (.mclk(mclk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .cpu_irq_mask(cpu_irq_mask), .stop_mode(stop_mode),
  .irq_req(irq_req), .pin_owned(pin_owned), .pin_drv(pin_drv));
`default_nettype wire

// ===== ssp_peer_model.sv
// Purpose: far-side serial device exchanging one byte a frame
// Assumes: clock line idles high; peer sends msb first
// Notes: never drives the clock
`timescale 1ns/100ps
`default_nettype none
module ssp_peer_model (
  // serial lines
  input wire logic sck,
  input wire logic din,
  output logic dout,
  // bench side
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic [7:0] got
);
  initial dout = 1'b1;
  always @(posedge sck or posedge load)
    if (load)
      got <= load_val;
    else
      got <= {got[6:0], din};
  // drive on fall; before the first fall show the wrong bit
  always @(negedge sck or posedge load)
    if (load)
      dout <= ~load_val[7];
    else
      dout <= got[7];
endmodule
`default_nettype wire

// ===== ssp_top_bench.sv
// Purpose: self-checking bench for the serial port
// Assumes: peer model on the far side; slow rate for data checks
// Notes: rows are ctl, tx, peer byte, irq expected
`timescale 1ns/100ps
`default_nettype none
module ssp_top_bench
  import ssp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  ssp_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic cpu_irq_mask = 1'b0;
  logic stop_mode = 1'b0;
  logic irq_req;
  logic [2:0] dir = 3'h0;
  logic [2:0] latch = 3'h0;
  logic [2:0] pin_owned, port_c_rdata, pin_in;
  ssp_pin_drv_t pin_drv;
  // clock line held high before enabling
  logic ext_sck = 1'b1;
  logic peer_dout;
  logic load = 1'b0;
  logic [7:0] load_val = 8'h00;
  logic [7:0] got;
  logic [31:0] r;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rows [6] = '{32'h513ca600, 32'h713ca600, 32'hd1815e01, 32'h40c31700,
    32'he00ff001, 32'hf1e71801};
  always #20 mclk = ~mclk;
  // wire levels; released data out line is pulled high
  assign pin_in = {pin_drv.oe[2] ? pin_drv.out[2] : ext_sck, pin_drv.oe[1] ? pin_drv.out[1] : 1'b1, peer_dout};
  ssp_top DUT (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_irq_mask(cpu_irq_mask), .stop_mode(stop_mode), .irq_req(irq_req),
    .port_c_direction(dir), .port_c_latch(latch), .pin_owned(pin_owned),
    .port_c_rdata(port_c_rdata), .pin_in(pin_in), .pin_drv(pin_drv));
  ssp_peer_model peer (.sck(pin_in[2]), .din(pin_in[1]), .dout(peer_dout), .load(load),
    .load_val(load_val), .got(got));
  function automatic logic [7:0] rv(input logic l, input logic [7:0] x);
    for (int k = 0; k < 8; k++)
      rv[k] = l ? x[7-k] : x[k];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus_req.rd <= 1'b0;
    #1 chk("rdata", e, bus_rdata);
  endtask
  // reload the peer byte between frames
  task automatic ld(input logic [7:0] v);
    @(posedge mclk) load_val <= v;
    load <= 1'b1;
    @(posedge mclk) load <= 1'b0;
  endtask
  // slave frame: eight pulses, 8 cycles a phase
  task automatic pulses();
    repeat (16)
    begin
      cyc(8);
      ext_sck <= ~ext_sck;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    cyc(50000);
    error_cnt++;
    conclude();
  end
  // control written only between frames, never during one
  initial
  begin
    cyc(20);
    rst_n <= 1'b1;
    rd(SSP_OFS_CONTROL, 8'h00); // control
    rd(SSP_OFS_STATUS, 8'h00); // flags
    chk("irq", 8'h00, {7'h0, irq_req}); // irq
    for (int i = 0; i < 6; i++)
    begin
      r = rows[i];
      wr(SSP_OFS_CONTROL, r[31:24]);
      ld(r[15:8]);
      wr(SSP_OFS_DATA, r[23:16]); // start
      if (r[28])
        cyc(136);
      else
        pulses();
      cyc(8);
      #1 chk("irq", r[7:0], {7'h0, irq_req}); // request
      // stop mode passes only a slave request; flags stay for later
      cyc(1);
      stop_mode <= 1'b1;
      cyc(1);
      #1 chk("irq_stop", r[28] ? 8'h00 : r[7:0], {7'h0, irq_req}); // stop gating
      cyc(1);
      stop_mode <= 1'b0;
      rd(SSP_OFS_STATUS, 8'h80); // done
      rd(SSP_OFS_DATA, rv(r[29], r[15:8])); // received
      rd(SSP_OFS_STATUS, 8'h00); // cleared
      chk("peer", rv(r[29], r[23:16]), got); // sent
    end
    // collision mid-frame, then a write while done
    wr(SSP_OFS_CONTROL, 8'hd1);
    ld(8'h99);
    wr(SSP_OFS_DATA, 8'ha5);
    wr(SSP_OFS_DATA, 8'h33); // discarded
    cyc(136);
    cpu_irq_mask <= 1'b1;
    cyc(1);
    #1 chk("irq", 8'h00, {7'h0, irq_req}); // masked
    cyc(1);
    {cpu_irq_mask, stop_mode} <= 2'b01;
    cyc(1);
    #1 chk("irq", 8'h00, {7'h0, irq_req}); // pending
    cyc(1);
    stop_mode <= 1'b0;
    wr(SSP_OFS_DATA, 8'h11); // ignored
    rd(SSP_OFS_STATUS, 8'hc0); // flags
    rd(SSP_OFS_DATA, 8'h99); // kept
    chk("peer", 8'ha5, got); // frame intact
    rd(SSP_OFS_STATUS, 8'h00); // cleared
    // fast rate, then disable mid-done
    wr(SSP_OFS_CONTROL, 8'h50);
    wr(SSP_OFS_DATA, 8'h00);
    cyc(20);
    rd(SSP_OFS_STATUS, 8'h80); // fast done
    wr(SSP_OFS_CONTROL, 8'h00);
    rd(SSP_OFS_STATUS, 8'h00); // flags reset
    chk("owned", 8'h00, {5'h0, pin_owned}); // released
    wr(SSP_OFS_DATA, 8'h5a);
    rd(SSP_OFS_DATA, 8'h5a); // storage
    wr(16'h000d, 8'hff);
    rd(16'h000d, 8'h00); // unmapped reads zero
    wr(SSP_OFS_CONTROL, 8'h5e);
    rd(SSP_OFS_CONTROL, 8'h50); // spare bits
    cyc(1);
    dir <= 3'h3;
    cyc(8);
    chk("portc", 8'h04, {5'h0, port_c_rdata}); // readback
    chk("owned", 8'h07, {5'h0, pin_owned}); // taken
    conclude();
  end
endmodule
`default_nettype wire
